// *** ufc_top.sv ***
// ufc_top: fifo control and line format registers of one uart channel
// assumes fifo storage, shifters and baud logic sit outside, driven by these ports
// Operation
// - fifo control reads back nothing
// - fifo enable bit enables both fifos
// - other fields load only with enable set
// - tx reset clears tx pointers and count
// - rx reset clears rx pointers and count
// - dma mode bit stored, no effect
// - rx condition when count reaches rx level
// - tx condition on falling below, or on emptying unless filled above the level
// - tx level select needs enhanced enable
// - one table select serves both directions
// - table a and b level sets
// - table c levels, table d programmable
// - selects reset to zero, levels one
// - line control readable and writable
// - divisor access bit redirects shared addresses
// - break bit holds tx output low
// - parity scheme from bits five to three
// - bits one to zero give length
// - bit two gives stop length
// - bit three enables parity both ways
//
// Implementation choices: the AXI4-Lite interface to the registers and the placing of the registers.
`timescale 1ns/1ps
module ufc_top (
	// clock and reset
	input  wire logic        aclk,
	input  wire logic        aresetn,
	// axi4-lite write
	input  wire logic        awvalid,
	output logic             awready,
	input  wire logic [7:0]  awaddr,
	input  wire logic        wvalid,
	output logic             wready,
	input  wire logic [31:0] wdata,
	input  wire logic [3:0]  wstrb,
	output logic             bvalid,
	input  wire logic        bready,
	output logic      [1:0]  bresp,
	// axi4-lite read
	input  wire logic        arvalid,
	output logic             arready,
	input  wire logic [7:0]  araddr,
	output logic             rvalid,
	input  wire logic        rready,
	output logic      [31:0] rdata,
	output logic      [1:0]  rresp,
	// tx fifo storage side
	output logic             tx_push,
	output logic      [7:0]  tx_wdata,
	output logic      [7:0]  tx_wr_ptr,
	output logic      [7:0]  tx_rd_ptr,
	input  wire logic        tx_pop,
	// rx fifo storage side
	input  wire logic        rx_push,
	output logic      [7:0]  rx_wr_ptr,
	output logic      [7:0]  rx_rd_ptr,
	input  wire logic [7:0]  rx_rdata,
	// line side
	input  wire logic        tx_serial,
	output logic             tx_out,
	output ufc_pkg::ufc_fmt_s fmt,
	output logic      [7:0]  divisor_low,
	output logic      [7:0]  divisor_high,
	output logic      [7:0]  divisor_fraction,
	// status
	output logic             fifo_en,
	output logic             rx_int_cond,
	output logic             tx_int_cond
);
	typedef struct packed {
		logic [7:0] awaddr;
		logic       aw_held;
		logic [7:0] wbyte;
		logic       wstrb0;
		logic       w_held;
		logic       bvalid;
		logic [1:0] bresp;
		logic       rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
		logic       fifo_en;
		logic       dma_mode;
		logic [1:0] rx_sel;
		logic [1:0] tx_sel;
		logic [7:0] line_control;
		logic [7:0] feature_control;
		logic [7:0] enhanced_feature_reg;
		logic [7:0] rx_level_reg;
		logic [7:0] tx_level_reg;
		logic [7:0] divisor_low;
		logic [7:0] divisor_high;
		logic [7:0] divisor_fraction;
		logic [7:0] scratch;
		logic [7:0] tx_wr_ptr;
		logic [7:0] tx_rd_ptr;
		logic [7:0] rx_wr_ptr;
		logic [7:0] rx_rd_ptr;
		logic [8:0] tx_cnt;
		logic [8:0] rx_cnt;
		logic       tx_int;
		logic       tx_filled;
		logic       tx_push;
		logic [7:0] tx_wdata;
	} ufc_state_s;

	localparam ufc_state_s ST_RST = '{
		line_control:         ufc_pkg::LINE_CTRL_RST,
		feature_control:      ufc_pkg::FEAT_CTRL_RST,
		enhanced_feature_reg: ufc_pkg::ENH_FEAT_RST,
		rx_level_reg:         ufc_pkg::RX_LEVEL_RST,
		tx_level_reg:         ufc_pkg::TX_LEVEL_RST,
		divisor_low:          ufc_pkg::DIV_LOW_RST,
		divisor_high:         ufc_pkg::DIV_HIGH_RST,
		divisor_fraction:     ufc_pkg::DIV_FRAC_RST,
		default:              '0
	};

	ufc_state_s st_reg;
	ufc_state_s st_next;
	logic       dlab;
	logic       wr_fire;
	logic       rd_fire;
	logic       fc_wr;
	logic       fc_ok;
	logic       tx_clr;
	logic       rx_clr;
	logic       wr_data;
	logic       rd_data;
	logic       rd_status;
	logic [8:0] cap;
	logic       tx_inc;
	logic       tx_dec;
	logic       rx_inc;
	logic       rx_dec;
	logic [8:0] tx_step;
	logic [8:0] rx_step;
	logic [7:0] rx_level;
	logic [7:0] tx_level;
	logic [8:0] tx_trig;
	logic [8:0] rx_trig;
	logic       tx_fell;
	logic       tx_emptied;
	logic [31:0] rd_word;

	// one table select feeds both directions
	ufc_trig_lut u_lut (
		.table_sel (st_reg.feature_control[ufc_pkg::FT_TABLE +: 2]),
		.rx_sel    (st_reg.rx_sel),
		.tx_sel    (st_reg.tx_sel),
		.rx_prog   (st_reg.rx_level_reg),
		.tx_prog   (st_reg.tx_level_reg),
		.rx_level  (rx_level),
		.tx_level  (tx_level)
	);

	assign dlab      = st_reg.line_control[ufc_pkg::LC_DLAB];
	assign awready   = !st_reg.aw_held && !st_reg.bvalid;
	assign wready    = !st_reg.w_held && !st_reg.bvalid;
	assign arready   = !st_reg.rvalid;
	assign wr_fire   = st_reg.aw_held && st_reg.w_held;
	assign rd_fire   = arvalid && arready;
	assign fc_wr     = wr_fire && st_reg.wstrb0 && st_reg.awaddr == ufc_pkg::OFS_FIFO_CTRL;
	assign fc_ok     = fc_wr && st_reg.wbyte[ufc_pkg::FC_ENABLE];
	assign tx_clr    = fc_ok && st_reg.wbyte[ufc_pkg::FC_TX_RST];
	assign rx_clr    = fc_ok && st_reg.wbyte[ufc_pkg::FC_RX_RST];
	assign wr_data   = wr_fire && st_reg.wstrb0 && st_reg.awaddr == ufc_pkg::OFS_DATA && !dlab;
	assign rd_data   = rd_fire && araddr == ufc_pkg::OFS_DATA && !dlab;
	assign rd_status = rd_fire && araddr == ufc_pkg::OFS_STATUS;

	// fifos disabled behave as a single holding slot
	assign cap     = st_reg.fifo_en ? ufc_pkg::FIFO_DEPTH : ufc_pkg::ONE_SLOT;
	assign tx_trig = st_reg.fifo_en ? {1'b0, tx_level} : ufc_pkg::ONE_SLOT;
	assign rx_trig = st_reg.fifo_en ? {1'b0, rx_level} : ufc_pkg::ONE_SLOT;
	assign tx_inc  = wr_data && st_reg.tx_cnt < cap;
	assign tx_dec  = tx_pop && st_reg.tx_cnt != 9'h000;
	assign rx_inc  = rx_push && st_reg.rx_cnt < cap;
	assign rx_dec  = rd_data && st_reg.rx_cnt != 9'h000;
	assign tx_step = ufc_pkg::cnt_step(st_reg.tx_cnt, tx_inc, tx_dec);
	assign rx_step = ufc_pkg::cnt_step(st_reg.rx_cnt, rx_inc, rx_dec);

	// a fifo reset is not a drain, so it raises nothing
	assign tx_fell    = !tx_clr && st_reg.tx_cnt >= tx_trig && tx_step < tx_trig;
	assign tx_emptied = !tx_clr && st_reg.tx_cnt != 9'h000 && tx_step == 9'h000
		&& !st_reg.tx_filled;

	always_comb
	begin
		rd_word = 32'h0000_0000;
		case (araddr)
			ufc_pkg::OFS_DATA:      rd_word = {24'h0, dlab ? st_reg.divisor_low : rx_rdata};
			ufc_pkg::OFS_AUX:       rd_word = {24'h0, dlab ? st_reg.divisor_high : st_reg.scratch};
			ufc_pkg::OFS_LINE_CTRL: rd_word = {24'h0, st_reg.line_control};
			ufc_pkg::OFS_FEAT_CTRL: rd_word = {24'h0, st_reg.feature_control};
			ufc_pkg::OFS_ENH_FEAT:  rd_word = {24'h0, st_reg.enhanced_feature_reg};
			ufc_pkg::OFS_RX_LEVEL:  rd_word = {24'h0, st_reg.rx_level_reg};
			ufc_pkg::OFS_TX_LEVEL:  rd_word = {24'h0, st_reg.tx_level_reg};
			ufc_pkg::OFS_STATUS:    rd_word = {24'h0, st_reg.fifo_en, st_reg.fifo_en, 2'b00,
				rx_int_cond, st_reg.tx_int, st_reg.dma_mode, st_reg.fifo_en};
			ufc_pkg::OFS_COUNT:     rd_word = dlab ? {24'h0, st_reg.divisor_fraction}
				: {7'h00, st_reg.rx_cnt, 7'h00, st_reg.tx_cnt};
			default:                rd_word = 32'h0000_0000;
		endcase
	end

	always_comb
	begin
		st_next = st_reg;
		st_next.tx_push = 1'b0;
		if (awvalid && awready)
		begin
			st_next.aw_held = 1'b1;
			st_next.awaddr  = awaddr;
		end
		if (wvalid && wready)
		begin
			st_next.w_held = 1'b1;
			st_next.wbyte  = wdata[7:0];
			st_next.wstrb0 = wstrb[0];
		end
		if (st_reg.bvalid && bready)
			st_next.bvalid = 1'b0;
		if (wr_fire)
		begin
			st_next.aw_held = 1'b0;
			st_next.w_held  = 1'b0;
			st_next.bvalid  = 1'b1;
			st_next.bresp   = ufc_pkg::reg_mapped(st_reg.awaddr) ? ufc_pkg::RESP_OKAY
				: ufc_pkg::RESP_SLVERR;
			// a write without lane 0 changes nothing
			if (st_reg.wstrb0)
			begin
				case (st_reg.awaddr)
					ufc_pkg::OFS_DATA:
					begin
						if (dlab)
							st_next.divisor_low = st_reg.wbyte;
						else if (tx_inc)
						begin
							st_next.tx_wdata = st_reg.wbyte;
							st_next.tx_push  = 1'b1;
						end
					end
					ufc_pkg::OFS_AUX:
					begin
						if (dlab)
							st_next.divisor_high = st_reg.wbyte;
						else
							st_next.scratch = st_reg.wbyte;
					end
					ufc_pkg::OFS_FIFO_CTRL:
					begin
						st_next.fifo_en = st_reg.wbyte[ufc_pkg::FC_ENABLE];
						if (st_reg.wbyte[ufc_pkg::FC_ENABLE])
						begin
							st_next.dma_mode = st_reg.wbyte[ufc_pkg::FC_DMA];
							st_next.rx_sel   = st_reg.wbyte[ufc_pkg::FC_RX_TRIG +: 2];
							if (st_reg.enhanced_feature_reg[ufc_pkg::EF_ENH])
								st_next.tx_sel = st_reg.wbyte[ufc_pkg::FC_TX_TRIG +: 2];
						end
					end
					ufc_pkg::OFS_LINE_CTRL: st_next.line_control         = st_reg.wbyte;
					ufc_pkg::OFS_FEAT_CTRL: st_next.feature_control      = st_reg.wbyte;
					ufc_pkg::OFS_ENH_FEAT:  st_next.enhanced_feature_reg = st_reg.wbyte;
					ufc_pkg::OFS_RX_LEVEL:  st_next.rx_level_reg         = st_reg.wbyte;
					ufc_pkg::OFS_TX_LEVEL:  st_next.tx_level_reg         = st_reg.wbyte;
					ufc_pkg::OFS_COUNT:
					begin
						if (dlab)
							st_next.divisor_fraction = st_reg.wbyte;
					end
					default: ;
				endcase
			end
		end
		if (rd_fire)
		begin
			st_next.rvalid = 1'b1;
			st_next.rdata  = rd_word;
			st_next.rresp  = ufc_pkg::reg_mapped(araddr) ? ufc_pkg::RESP_OKAY
				: ufc_pkg::RESP_SLVERR;
		end
		else if (st_reg.rvalid && rready)
			st_next.rvalid = 1'b0;

		// pointer resets leave the shifters outside untouched
		if (tx_clr)
		begin
			st_next.tx_wr_ptr = 8'h00;
			st_next.tx_rd_ptr = 8'h00;
			st_next.tx_cnt    = 9'h000;
			st_next.tx_filled = 1'b0;
		end
		else
		begin
			if (tx_inc)
				st_next.tx_wr_ptr = st_reg.tx_wr_ptr + 8'h01;
			if (tx_dec)
				st_next.tx_rd_ptr = st_reg.tx_rd_ptr + 8'h01;
			st_next.tx_cnt = tx_step;
			if (tx_step > tx_trig)
				st_next.tx_filled = 1'b1;
			else if (tx_step == 9'h000)
				st_next.tx_filled = 1'b0;
		end
		if (rx_clr)
		begin
			st_next.rx_wr_ptr = 8'h00;
			st_next.rx_rd_ptr = 8'h00;
			st_next.rx_cnt    = 9'h000;
		end
		else
		begin
			// a character arriving into a full fifo is dropped
			if (rx_inc)
				st_next.rx_wr_ptr = st_reg.rx_wr_ptr + 8'h01;
			if (rx_dec)
				st_next.rx_rd_ptr = st_reg.rx_rd_ptr + 8'h01;
			st_next.rx_cnt = rx_step;
		end

		// set beats the clear from a data write or status read
		if (tx_fell || tx_emptied)
			st_next.tx_int = 1'b1;
		else if (wr_data || rd_status)
			st_next.tx_int = 1'b0;
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			st_reg <= ST_RST;
		else
			st_reg <= st_next;
	end

	always_comb
	begin
		fmt.word_bits = ufc_pkg::WORD_MIN
			+ {2'b00, st_reg.line_control[ufc_pkg::LC_WLEN +: 2]};
		if (!st_reg.line_control[ufc_pkg::LC_STOP])
			fmt.stop_halves = ufc_pkg::STOP_ONE;
		else if (st_reg.line_control[ufc_pkg::LC_WLEN +: 2] == 2'b00)
			fmt.stop_halves = ufc_pkg::STOP_ONE_HALF;
		else
			fmt.stop_halves = ufc_pkg::STOP_TWO;
		if (!st_reg.line_control[ufc_pkg::LC_PEN])
			fmt.parity = ufc_pkg::PAR_NONE;
		else
		begin
			case ({st_reg.line_control[ufc_pkg::LC_FORCE], st_reg.line_control[ufc_pkg::LC_EVEN]})
				2'b00:   fmt.parity = ufc_pkg::PAR_ODD;
				2'b01:   fmt.parity = ufc_pkg::PAR_EVEN;
				2'b10:   fmt.parity = ufc_pkg::PAR_MARK;
				default: fmt.parity = ufc_pkg::PAR_SPACE;
			endcase
		end
		fmt.brk = st_reg.line_control[ufc_pkg::LC_BREAK];
	end

	assign tx_out           = st_reg.line_control[ufc_pkg::LC_BREAK] ? 1'b0 : tx_serial;
	assign rx_int_cond      = st_reg.rx_cnt >= rx_trig;
	assign tx_int_cond      = st_reg.tx_int;
	assign fifo_en          = st_reg.fifo_en;
	assign bvalid           = st_reg.bvalid;
	assign bresp            = st_reg.bresp;
	assign rvalid           = st_reg.rvalid;
	assign rdata            = st_reg.rdata;
	assign rresp            = st_reg.rresp;
	assign tx_push          = st_reg.tx_push;
	assign tx_wdata         = st_reg.tx_wdata;
	assign tx_wr_ptr        = st_reg.tx_wr_ptr;
	assign tx_rd_ptr        = st_reg.tx_rd_ptr;
	assign rx_wr_ptr        = st_reg.rx_wr_ptr;
	assign rx_rd_ptr        = st_reg.rx_rd_ptr;
	assign divisor_low      = st_reg.divisor_low;
	assign divisor_high     = st_reg.divisor_high;
	assign divisor_fraction = st_reg.divisor_fraction;

	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);

	sequence s_fc_wr;
		wr_fire && st_reg.wstrb0 && st_reg.awaddr == ufc_pkg::OFS_FIFO_CTRL;
	endsequence
	sequence s_lc_wr;
		wr_fire && st_reg.wstrb0 && st_reg.awaddr == ufc_pkg::OFS_LINE_CTRL;
	endsequence

	property p_fc_blind;
		rd_fire && araddr == ufc_pkg::OFS_FIFO_CTRL |=> rvalid && rdata == 32'h0000_0000;
	endproperty
	a_fc_blind: assert property (p_fc_blind) else $error("fifo control read not zero");

	property p_fifo_en;
		s_fc_wr |=> fifo_en == $past(st_reg.wbyte[ufc_pkg::FC_ENABLE]);
	endproperty
	a_fifo_en: assert property (p_fifo_en) else $error("fifo enable not loaded");

	property p_gated;
		s_fc_wr ##0 !st_reg.wbyte[ufc_pkg::FC_ENABLE] |=> $stable(st_reg.rx_sel)
			&& $stable(st_reg.tx_sel) && $stable(st_reg.dma_mode);
	endproperty
	a_gated: assert property (p_gated) else $error("fields loaded without enable");

	property p_tx_clr;
		s_fc_wr ##0 (st_reg.wbyte[0] && st_reg.wbyte[2]) |=> st_reg.tx_cnt == 9'h000
			&& tx_wr_ptr == 8'h00 && tx_rd_ptr == 8'h00;
	endproperty
	a_tx_clr: assert property (p_tx_clr) else $error("tx fifo not cleared");

	property p_rx_clr;
		s_fc_wr ##0 (st_reg.wbyte[0] && st_reg.wbyte[1]) |=> st_reg.rx_cnt == 9'h000
			&& rx_wr_ptr == 8'h00 && rx_rd_ptr == 8'h00;
	endproperty
	a_rx_clr: assert property (p_rx_clr) else $error("rx fifo not cleared");

	property p_tx_lock;
		s_fc_wr ##0 !st_reg.enhanced_feature_reg[ufc_pkg::EF_ENH] |=> $stable(st_reg.tx_sel);
	endproperty
	a_tx_lock: assert property (p_tx_lock) else $error("tx select changed while locked");

	property p_tbl_a;
		st_reg.feature_control[7:6] == 2'b00 |-> tx_level == 8'h01
			&& (st_reg.rx_sel != 2'b11 || rx_level == 8'h0e);
	endproperty
	a_tbl_a: assert property (p_tbl_a) else $error("table a level wrong");

	property p_tx_ev;
		tx_fell |=> tx_int_cond ##1 (tx_int_cond || $past(wr_data || rd_status));
	endproperty
	a_tx_ev: assert property (p_tx_ev) else $error("tx condition lost");

	property p_lc_rw;
		rd_fire && araddr == ufc_pkg::OFS_LINE_CTRL |=>
			rdata[7:0] == $past(st_reg.line_control) && rdata[31:8] == 24'h0;
	endproperty
	a_lc_rw: assert property (p_lc_rw) else $error("line control read mismatch");

	property p_lc_wr;
		s_lc_wr |=> st_reg.line_control == $past(st_reg.wbyte);
	endproperty
	a_lc_wr: assert property (p_lc_wr) else $error("line control write lost");

	property p_brk;
		fmt.brk |-> !tx_out;
	endproperty
	a_brk: assert property (p_brk) else $error("break not holding tx low");

	property p_dlab_rd;
		rd_fire && araddr == ufc_pkg::OFS_DATA && dlab && !rx_clr |=>
			rdata == {24'h0, $past(st_reg.divisor_low)} && $stable(st_reg.rx_rd_ptr);
	endproperty
	a_dlab_rd: assert property (p_dlab_rd) else $error("divisor access read wrong");
endmodule

// *** ufc_pkg.sv ***
// ufc_pkg: offsets, fields, resets and types of the fifo and line format block
// assumes a 32-bit axi4-lite slave with 8-bit registers in the low byte, except the count word with rx and tx counts in two halves
package ufc_pkg;
	localparam logic [7:0] OFS_DATA      = 8'h00;
	localparam logic [7:0] OFS_AUX       = 8'h04;
	localparam logic [7:0] OFS_FIFO_CTRL = 8'h08;
	localparam logic [7:0] OFS_LINE_CTRL = 8'h0c;
	localparam logic [7:0] OFS_FEAT_CTRL = 8'h10;
	localparam logic [7:0] OFS_ENH_FEAT  = 8'h14;
	localparam logic [7:0] OFS_RX_LEVEL  = 8'h18;
	localparam logic [7:0] OFS_TX_LEVEL  = 8'h1c;
	localparam logic [7:0] OFS_STATUS    = 8'h20;
	localparam logic [7:0] OFS_COUNT     = 8'h24;

	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// fifo_control fields
	localparam int FC_ENABLE  = 0;
	localparam int FC_RX_RST  = 1;
	localparam int FC_TX_RST  = 2;
	localparam int FC_DMA     = 3;
	localparam int FC_TX_TRIG = 4;
	localparam int FC_RX_TRIG = 6;
	// line_control fields, then the enhanced bit and the table select field
	localparam int LC_WLEN   = 0;
	localparam int LC_STOP   = 2;
	localparam int LC_PEN    = 3;
	localparam int LC_EVEN   = 4;
	localparam int LC_FORCE  = 5;
	localparam int LC_BREAK  = 6;
	localparam int LC_DLAB   = 7;
	localparam int EF_ENH    = 4;
	localparam int FT_TABLE  = 6;

	localparam logic [7:0] LINE_CTRL_RST = 8'h00;
	localparam logic [7:0] FEAT_CTRL_RST = 8'h00;
	localparam logic [7:0] ENH_FEAT_RST  = 8'h00;
	localparam logic [7:0] RX_LEVEL_RST  = 8'h01;
	localparam logic [7:0] TX_LEVEL_RST  = 8'h01;
	localparam logic [7:0] DIV_LOW_RST   = 8'h01;
	localparam logic [7:0] DIV_HIGH_RST  = 8'h00;
	localparam logic [7:0] DIV_FRAC_RST  = 8'h00;

	localparam logic [8:0] FIFO_DEPTH = 9'h100;
	localparam logic [8:0] ONE_SLOT   = 9'h001;

	localparam logic [7:0]      TX_TRIG_A = 8'h01;
	localparam logic [3:0][7:0] RX_TRIG_A = {8'h0e, 8'h08, 8'h04, 8'h01};
	localparam logic [3:0][7:0] RX_TRIG_B = {8'h1c, 8'h18, 8'h10, 8'h08};
	localparam logic [3:0][7:0] TX_TRIG_B = {8'h1e, 8'h18, 8'h08, 8'h10};
	localparam logic [3:0][7:0] RX_TRIG_C = {8'h3c, 8'h38, 8'h10, 8'h08};
	localparam logic [3:0][7:0] TX_TRIG_C = {8'h38, 8'h20, 8'h10, 8'h08};

	localparam logic [3:0] WORD_MIN      = 4'h5;
	localparam logic [2:0] STOP_ONE      = 3'h2;
	localparam logic [2:0] STOP_ONE_HALF = 3'h3;
	localparam logic [2:0] STOP_TWO      = 3'h4;

	typedef enum logic [1:0] {TBL_A = 2'b00, TBL_B = 2'b01, TBL_C = 2'b10, TBL_D = 2'b11} ufc_tbl_e;
	typedef enum logic [2:0] {PAR_NONE = 3'b000, PAR_ODD = 3'b001, PAR_EVEN = 3'b010,
		PAR_MARK = 3'b011, PAR_SPACE = 3'b100} ufc_par_e;

	// stop length counted in half bit times
	typedef struct packed {
		logic [3:0] word_bits;
		logic [2:0] stop_halves;
		ufc_par_e   parity;
		logic       brk;
	} ufc_fmt_s;

	function automatic logic [8:0] cnt_step(input logic [8:0] c, input logic inc, input logic dec);
		case ({inc, dec})
			2'b10: return c + ONE_SLOT;
			2'b01: return c - ONE_SLOT;
			default: return c;
		endcase
	endfunction

	function automatic logic reg_mapped(input logic [7:0] a);
		return (a[1:0] == 2'b00) && (a <= OFS_COUNT);
	endfunction
endpackage

// *** ufc_trig_lut.sv ***
// ufc_trig_lut: trigger level lookup over the four shared tables
// assumes selects come straight from the control registers
`timescale 1ns/1ps
module ufc_trig_lut (
	// selects
	input  wire logic [1:0] table_sel,
	input  wire logic [1:0] rx_sel,
	input  wire logic [1:0] tx_sel,
	// programmable levels
	input  wire logic [7:0] rx_prog,
	input  wire logic [7:0] tx_prog,
	// levels
	output logic      [7:0] rx_level,
	output logic      [7:0] tx_level
);
	always_comb
	begin
		case (ufc_pkg::ufc_tbl_e'(table_sel))
			ufc_pkg::TBL_A:
			begin
				rx_level = ufc_pkg::RX_TRIG_A[rx_sel];
				tx_level = ufc_pkg::TX_TRIG_A;
			end
			ufc_pkg::TBL_B:
			begin
				rx_level = ufc_pkg::RX_TRIG_B[rx_sel];
				tx_level = ufc_pkg::TX_TRIG_B[tx_sel];
			end
			ufc_pkg::TBL_C:
			begin
				rx_level = ufc_pkg::RX_TRIG_C[rx_sel];
				tx_level = ufc_pkg::TX_TRIG_C[tx_sel];
			end
			default:
			begin
				// selects ignored, levels fully programmable
				rx_level = rx_prog;
				tx_level = tx_prog;
			end
		endcase
	end
endmodule

// *** test_uart_fifo_and_line_format_ctrl.sv ***
// test_uart_fifo_and_line_format_ctrl: self-checking bench for ufc_top
// assumes ufc_pkg is compiled first; the bench is axi4-lite master, fifo side and line side
`timescale 1ns/1ps
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin err_total++; \
	$display("FAIL %s expected %h seen %h", nm, e, g); end end
module test_uart_fifo_and_line_format_ctrl;
	logic              aclk      = 1'h0;
	logic              aresetn   = 1'h0;
	logic              awvalid   = 1'h0;
	logic              wvalid    = 1'h0;
	logic              arvalid   = 1'h0;
	logic              bready    = 1'h1;
	logic              rready    = 1'h1;
	logic              tx_pop    = 1'h0;
	logic              rx_push   = 1'h0;
	logic              tx_serial = 1'h1;
	logic [7:0]        awaddr    = 8'h00;
	logic [7:0]        araddr    = 8'h00;
	logic [7:0]        rx_rdata  = 8'h00;
	logic [31:0]       wdata     = 32'h0;
	logic [3:0]        wstrb     = 4'hf;
	logic              awready, wready, bvalid, arready, rvalid;
	logic              tx_push, tx_out, fifo_en, rx_int_cond, tx_int_cond;
	logic [1:0]        bresp, rresp;
	logic [31:0]       rdata;
	logic [7:0]        tx_wdata, tx_wr_ptr, tx_rd_ptr, rx_wr_ptr, rx_rd_ptr;
	logic [7:0]        divisor_low, divisor_high, divisor_fraction;
	ufc_pkg::ufc_fmt_s fmt;
	ufc_pkg::ufc_fmt_s exp_fmt;
	int                err_total  = 0;
	int                n_compared = 0;
	int                seed       = 82;
	int                n_push     = 0;
	logic [33:0]       exp_q[$];
	logic [33:0]       got_e;
	logic [7:0]        lc;
	logic [7:0]        d;
	logic [8:0]        rx_n;
	logic [1:0]        tb[7] = '{2'h0, 2'h0, 2'h1, 2'h1, 2'h2, 2'h2, 2'h3};
	logic [1:0]        sl[7] = '{2'h3, 2'h0, 2'h3, 2'h1, 2'h2, 2'h3, 2'h2};
	logic [7:0]        lv[7] = '{8'h0e, 8'h01, 8'h1c, 8'h10, 8'h38, 8'h3c, 8'h00};

	ufc_top i_dut (
		.aclk(aclk), .aresetn(aresetn),
		.awvalid(awvalid), .awready(awready), .awaddr(awaddr),
		.wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(wstrb),
		.bvalid(bvalid), .bready(bready), .bresp(bresp),
		.arvalid(arvalid), .arready(arready), .araddr(araddr),
		.rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp),
		.tx_push(tx_push), .tx_wdata(tx_wdata), .tx_wr_ptr(tx_wr_ptr),
		.tx_rd_ptr(tx_rd_ptr), .tx_pop(tx_pop),
		.rx_push(rx_push), .rx_wr_ptr(rx_wr_ptr), .rx_rd_ptr(rx_rd_ptr), .rx_rdata(rx_rdata),
		.tx_serial(tx_serial), .tx_out(tx_out), .fmt(fmt),
		.divisor_low(divisor_low), .divisor_high(divisor_high),
		.divisor_fraction(divisor_fraction),
		.fifo_en(fifo_en), .rx_int_cond(rx_int_cond), .tx_int_cond(tx_int_cond)
	);

	always #2 aclk = ~aclk;

	// line side keeps moving so break forcing is seen against both levels
	always @(posedge aclk)
	begin
		tx_serial <= 1'($random(seed));
		rx_rdata  <= 8'($random(seed));
	end

	// read answers are taken at the rready edge, oldest note first
	always @(posedge aclk)
	begin
		if (rvalid && rready)
		begin
			got_e = (exp_q.size() > 0) ? exp_q.pop_front() : 34'h3ffffffff;
			`CHK("rdata", got_e[31:0], rdata)
			`CHK("rresp", got_e[33:32], rresp)
		end
	end

	// push strobe lasts one cycle, so it is counted where it stands
	always @(posedge aclk)
		if (tx_push) n_push++;

	task automatic wr(input logic [7:0] a, input logic [7:0] v);
		awaddr  <= a;
		wdata   <= {24'h0, v};
		awvalid <= 1'h1;
		wvalid  <= 1'h1;
		do
		begin
			@(posedge aclk);
			if (awready) awvalid <= 1'h0;
			if (wready) wvalid <= 1'h0;
		end while (!bvalid);
		`CHK("bresp", ufc_pkg::RESP_OKAY, bresp)
		#1;
	endtask

	task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] r);
		exp_q.push_back({r, e});
		araddr  <= a;
		arvalid <= 1'h1;
		do @(posedge aclk); while (!arready);
		arvalid <= 1'h0;
		do @(posedge aclk); while (!rvalid);
		#1;
	endtask

	// back-to-back receive pulses, one char per cycle
	task automatic push(input logic [7:0] n);
		if (n > 8'h00)
		begin
			@(posedge aclk);
			rx_push <= 1'h1;
			repeat (n) @(posedge aclk);
			rx_push <= 1'h0;
		end
		@(posedge aclk);
		#1;
	endtask

	// back-to-back shifter pulls, one char per cycle
	task automatic pop(input logic [7:0] n);
		@(posedge aclk);
		tx_pop <= 1'h1;
		repeat (n) @(posedge aclk);
		tx_pop <= 1'h0;
		@(posedge aclk);
		#1;
	endtask

	task automatic results;
		if (err_total == 0 && n_compared > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask

	initial
	begin
		#200000;
		err_total++;
		results();
	end

	initial
	begin
		repeat (20) @(posedge aclk);
		aresetn <= 1'h1;
		#1;
		`CHK("fifo_en", 1'h0, fifo_en)
		rd(ufc_pkg::OFS_LINE_CTRL, 32'h0, ufc_pkg::RESP_OKAY);
		// each table and rx select sets the rx level, checked one below and at the level
		lv[6] = 8'(2 + {$random(seed)} % 40);
		wr(ufc_pkg::OFS_RX_LEVEL, lv[6]);
		for (int i = 0; i < 7; i++)
		begin
			wr(ufc_pkg::OFS_FEAT_CTRL, {tb[i], 6'h00});
			wr(ufc_pkg::OFS_FIFO_CTRL, {sl[i], 4'h0, 2'h3});
			`CHK("fifo_en", 1'h1, fifo_en)
			push(lv[i] - 8'h01);
			`CHK("rx_below", 1'h0, rx_int_cond)
			push(8'h01);
			`CHK("rx_at", 1'h1, rx_int_cond)
		end
		rx_n = {1'h0, lv[6]};
		`CHK("rx_wr_ptr", lv[6], rx_wr_ptr)
		wr(ufc_pkg::OFS_LINE_CTRL, 8'h80);
		d = 8'($random(seed));
		wr(ufc_pkg::OFS_DATA, d);
		`CHK("div_low", d, divisor_low)
		rd(ufc_pkg::OFS_DATA, {24'h0, d}, ufc_pkg::RESP_OKAY);
		wr(ufc_pkg::OFS_AUX, ~d);
		`CHK("div_high", ~d, divisor_high)
		wr(ufc_pkg::OFS_COUNT, d ^ 8'h5a);
		`CHK("div_frac", d ^ 8'h5a, divisor_fraction)
		wr(ufc_pkg::OFS_LINE_CTRL, 8'h00);
		repeat (3) wr(ufc_pkg::OFS_DATA, d);
		rd(ufc_pkg::OFS_COUNT, {7'h0, rx_n, 7'h0, 9'h003}, ufc_pkg::RESP_OKAY);
		wr(ufc_pkg::OFS_FIFO_CTRL, 8'h05);
		rd(ufc_pkg::OFS_COUNT, {7'h0, rx_n, 16'h0}, ufc_pkg::RESP_OKAY);
		wr(ufc_pkg::OFS_FIFO_CTRL, 8'h03);
		rd(ufc_pkg::OFS_COUNT, 32'h0, ufc_pkg::RESP_OKAY);
		rd(ufc_pkg::OFS_FIFO_CTRL, 32'h0, ufc_pkg::RESP_OKAY);
		// table b tx level 8, reachable only once the enhanced bit is set
		wr(ufc_pkg::OFS_ENH_FEAT, 8'h10);
		wr(ufc_pkg::OFS_FEAT_CTRL, 8'h40);
		wr(ufc_pkg::OFS_FIFO_CTRL, 8'h19);
		repeat (10)
		begin
			d = 8'($random(seed));
			wr(ufc_pkg::OFS_DATA, d);
		end
		`CHK("tx_wdata", d, tx_wdata)
		`CHK("tx_wr_ptr", 8'h0a, tx_wr_ptr)
		`CHK("tx_push", 13, n_push)
		pop(8'h02);
		`CHK("tx_above", 1'h0, tx_int_cond)
		pop(8'h01);
		`CHK("tx_below", 1'h1, tx_int_cond)
		`CHK("tx_rd_ptr", 8'h03, tx_rd_ptr)
		rd(ufc_pkg::OFS_STATUS, 32'h0000_00c7, ufc_pkg::RESP_OKAY);
		`CHK("tx_cleared", 1'h0, tx_int_cond)
		// filled above the level, so emptying raises nothing
		pop(8'h07);
		`CHK("tx_empty_full", 1'h0, tx_int_cond)
		repeat (2) wr(ufc_pkg::OFS_DATA, d);
		pop(8'h02);
		`CHK("tx_empty", 1'h1, tx_int_cond)
		wr(ufc_pkg::OFS_FIFO_CTRL, 8'h00);
		`CHK("fifo_en", 1'h0, fifo_en)
		rd(8'h28, 32'h0, ufc_pkg::RESP_SLVERR);
		rd(8'h09, 32'h0, ufc_pkg::RESP_SLVERR);
		// every parity code, random length and stop, break from bit one of the index
		for (int i = 0; i < 8; i++)
		begin
			lc = 8'($random(seed));
			lc[5:3] = 3'(i);
			lc[6] = 1'(i >> 1);
			lc[7] = 1'h0;
			wr(ufc_pkg::OFS_LINE_CTRL, lc);
			rd(ufc_pkg::OFS_LINE_CTRL, {24'h0, lc}, ufc_pkg::RESP_OKAY);
			exp_fmt.word_bits = ufc_pkg::WORD_MIN + {2'h0, lc[1:0]};
			exp_fmt.stop_halves = !lc[2] ? ufc_pkg::STOP_ONE :
				(lc[1:0] == 2'h0 ? ufc_pkg::STOP_ONE_HALF : ufc_pkg::STOP_TWO);
			exp_fmt.parity = !lc[3] ? ufc_pkg::PAR_NONE : lc[5] ?
				(lc[4] ? ufc_pkg::PAR_SPACE : ufc_pkg::PAR_MARK) :
				(lc[4] ? ufc_pkg::PAR_EVEN : ufc_pkg::PAR_ODD);
			exp_fmt.brk = lc[6];
			`CHK("fmt", exp_fmt, fmt)
			`CHK("tx_out", lc[6] ? 1'h0 : tx_serial, tx_out)
		end
		repeat (2) @(posedge aclk);
		results();
	end
endmodule
